// ### pcg_top.sv
// Behaviour
// - A soft reset request pulses one peripheral's reset, then releases it clocked.
// - Sleep enable clear gates that peripheral's clock while processor sleeps.
// - Leaving sleep restores clock of run-enabled peripherals, state kept, no reset.
// - Sleep enables act only while the auto gating switch is set; stored regardless.
// - Sleep-enabled peripherals keep their clock during sleep; configuration unchanged.
// - Pin presence reads true for existing pins, false otherwise, read-only.
// - Run enables clear at reset; disabled peripherals get no clock nor access.
// - Peripheral becomes active five cycles after run enable; accesses before then fault.
module pcg_top
    import pcg_pkg::*;
#(
    parameter logic [31:0] PIN_PRESENT_MAP = 32'hffff_ffff
) (
    input  wire logic                        clk_sys,          // System clock
    input  wire logic                        rst_n,            // Async reset, active low
    input  wire pcg_pkg::pcg_bus_s           bus,              // Register request
    output logic [pcg_pkg::DATA_W-1:0]       rdata,            // Read data, cycle after read
    input  wire logic                        cpu_sleep,        // Processor in sleep mode
    input  wire logic [pcg_pkg::NUM_PERIPH-1:0] periph_access, // Bus access per peripheral
    output logic [pcg_pkg::NUM_PERIPH-1:0]   periph_clk_en,    // Clock gate enable
    output logic [pcg_pkg::NUM_PERIPH-1:0]   periph_rst,       // Peripheral reset, high active
    output logic [pcg_pkg::NUM_PERIPH-1:0]   periph_active,    // Peripheral may be accessed
    output logic                             bus_fault         // Access to peripheral not ready
);
    import pcg_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [NUM_PERIPH-1:0] run_en, next_run_en;
    logic [NUM_PERIPH-1:0] sleep_en, next_sleep_en;
    logic                  gating, next_gating;
    logic [SEL_W-1:0]      pin_sel, next_pin_sel;
    logic [DATA_W-1:0]     next_rdata;
    logic [2:0]            en_cnt [NUM_PERIPH];
    logic [2:0]            next_en_cnt [NUM_PERIPH];
    logic [NUM_PERIPH-1:0] next_active;
    pcg_rst_e              rst_state, next_rst_state;
    logic [SEL_W-1:0]      rst_sel, next_rst_sel;
    logic [2:0]            rst_cnt, next_rst_cnt;
    logic [NUM_PERIPH-1:0] next_clk_en, next_periph_rst;
    logic                  next_fault;

    // One-hot of a selector field
    function automatic logic [NUM_PERIPH-1:0] onehot(input logic [SEL_W-1:0] s);
        return NUM_PERIPH'(1) << s;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] off);
        return bus.wr && (bus.addr == off);
    endfunction

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Only the low selector bits are used, so exactly one peripheral is hit per write
    always_comb begin
        next_run_en   = run_en;
        next_sleep_en = sleep_en;
        next_gating   = gating;
        next_pin_sel  = pin_sel;
        if (hit(OFF_RUN_ON)) begin
            next_run_en = run_en | onehot(bus.wdata[SEL_W-1:0]);
        end else if (hit(OFF_RUN_OFF)) begin
            next_run_en = run_en & ~onehot(bus.wdata[SEL_W-1:0]);
        end else if (hit(OFF_SLEEP_ON)) begin
            next_sleep_en = sleep_en | onehot(bus.wdata[SEL_W-1:0]);
        end else if (hit(OFF_SLEEP_OFF)) begin
            next_sleep_en = sleep_en & ~onehot(bus.wdata[SEL_W-1:0]);
        end else if (hit(OFF_GATING)) begin
            next_gating = bus.wdata[GATING_BIT];
        end else if (hit(OFF_PIN_QUERY)) begin
            next_pin_sel = bus.wdata[SEL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_en   <= RUN_RESET;
            sleep_en <= SLEEP_RESET;
            gating   <= GATE_RESET;
            pin_sel  <= '0;
        end else begin
            run_en   <= next_run_en;
            sleep_en <= next_sleep_en;
            gating   <= next_gating;
            pin_sel  <= next_pin_sel;
        end
    end

    // ************************************************************
    // Enable delay counters
    // ************************************************************
    // A peripheral turns active five cycles after its run enable is written
    always_comb begin
        for (int i = 0; i < NUM_PERIPH; i++) begin
            next_en_cnt[i] = en_cnt[i];
            next_active[i] = periph_active[i];
            if (!next_run_en[i]) begin
                next_en_cnt[i] = '0;
                next_active[i] = 1'b0;
            end else if (!run_en[i]) begin
                next_en_cnt[i] = ENABLE_DELAY_W - 3'd1;
                next_active[i] = 1'b0;
            end else if (en_cnt[i] != 3'd0) begin
                next_en_cnt[i] = en_cnt[i] - 3'd1;
                next_active[i] = (en_cnt[i] == 3'd1);
            end
        end
        next_fault = |(periph_access & ~periph_active);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PERIPH; i++) begin
                en_cnt[i] <= '0;
            end
            periph_active <= '0;
            bus_fault     <= 1'b0;
        end else begin
            en_cnt        <= next_en_cnt;
            periph_active <= next_active;
            bus_fault     <= next_fault;
        end
    end

    // ************************************************************
    // Soft reset sequencer
    // ************************************************************
    // One request at a time; a request during a pulse is dropped
    always_comb begin
        next_rst_state  = rst_state;
        next_rst_sel    = rst_sel;
        next_rst_cnt    = rst_cnt;
        next_periph_rst = '0;
        case (rst_state)
            RST_IDLE: begin
                if (hit(OFF_SOFT_RESET)) begin
                    next_rst_state  = RST_PULSE;
                    next_rst_sel    = bus.wdata[SEL_W-1:0];
                    next_rst_cnt    = RESET_PULSE_W - 3'd1;
                    next_periph_rst = onehot(bus.wdata[SEL_W-1:0]);
                end
            end
            RST_PULSE: begin
                if (rst_cnt == 3'd0) begin
                    next_rst_state = RST_IDLE;
                end else begin
                    next_rst_cnt    = rst_cnt - 3'd1;
                    next_periph_rst = onehot(rst_sel);
                end
            end
            default: begin
                next_rst_state = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_state  <= RST_IDLE;
            rst_sel    <= '0;
            rst_cnt    <= '0;
            periph_rst <= '0;
        end else begin
            rst_state  <= next_rst_state;
            rst_sel    <= next_rst_sel;
            rst_cnt    <= next_rst_cnt;
            periph_rst <= next_periph_rst;
        end
    end

    // ************************************************************
    // Clock gating
    // ************************************************************
    // Gating depends only on live enables, so waking never disturbs state
    always_comb begin
        if (cpu_sleep && gating) begin
            next_clk_en = run_en & sleep_en;
        end else begin
            next_clk_en = run_en;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            periph_clk_en <= '0;
        end else begin
            periph_clk_en <= next_clk_en;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Read mux; write-only offsets read as zero, but the gating switch and pin selector read back at OFF_GATING and OFF_PIN_QUERY
    always_comb begin
        next_rdata = READ_UNMAPPED;
        if (!bus.rd) begin
            next_rdata = READ_UNMAPPED;
        end else if (bus.addr == OFF_PIN_RESULT) begin
            next_rdata = {31'h0, PIN_PRESENT_MAP[pin_sel]};
        end else if (bus.addr == OFF_RUN_STATE) begin
            next_rdata = run_en;
        end else if (bus.addr == OFF_SLEEP_STATE) begin
            next_rdata = sleep_en;
        end else if (bus.addr == OFF_ACTIVE) begin
            next_rdata = periph_active;
        end else if (bus.addr == OFF_GATING) begin
            next_rdata = {31'h0, gating};
        end else if (bus.addr == OFF_PIN_QUERY) begin
            next_rdata = {27'h0, pin_sel};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Checks: soft reset and clocking
    // ************************************************************
    // Pulse is exactly four cycles long and then drops
    a_reset_pulse_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rst_state == RST_IDLE && hit(OFF_SOFT_RESET)) |=> (|periph_rst)[*4] ##1 !(|periph_rst))
        else $error("soft reset pulse length wrong");
    // A peripheral under soft reset keeps its clock, so it comes out running
    a_reset_keeps_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (|(periph_rst & run_en) && !cpu_sleep && $stable(run_en) && $stable(cpu_sleep))
        |=> |(periph_clk_en & $past(periph_rst)))
        else $error("peripheral lost clock during soft reset");
    // A pulse only ever names one peripheral
    a_reset_one_hot: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $onehot0(periph_rst))
        else $error("soft reset hit several peripherals");
    // Reset lines stay low without a request, so waking never resets anything
    a_wake_no_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rst_state == RST_IDLE && !hit(OFF_SOFT_RESET)) |=> (periph_rst == '0))
        else $error("peripheral reset without request");
    // With the switch set, sleep-disabled peripherals lose their clock one cycle into sleep
    a_sleep_gate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_sleep && gating) |=> ((periph_clk_en & ~$past(sleep_en)) == '0))
        else $error("sleep disabled peripheral still clocked");
    // Awake, every run-enabled peripheral is clocked
    a_wake_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!cpu_sleep) |=> (periph_clk_en == $past(run_en)))
        else $error("run peripheral not clocked after wake");
    // Switch off: the stored sleep enables are ignored
    a_gating_off_ignores: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!gating) |=> (periph_clk_en == $past(run_en)))
        else $error("sleep enables acted with gating off");
    // Stored sleep enables move only on their own writes, whatever the switch
    a_sleep_en_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!hit(OFF_SLEEP_ON) && !hit(OFF_SLEEP_OFF)) |=> $stable(sleep_en))
        else $error("sleep enables changed without a write");
    // Sleep-enabled peripherals keep running so their events can wake the processor
    a_sleep_keep_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cpu_sleep) |=> ((periph_clk_en & $past(run_en) & $past(sleep_en))
        == ($past(run_en) & $past(sleep_en))))
        else $error("sleep enabled peripheral lost clock");

    // ************************************************************
    // Checks: enables, faults and readout
    // ************************************************************
    // Presence result follows the selected pin
    a_pin_presence: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus.rd && bus.addr == OFF_PIN_RESULT)
        |=> (rdata == {31'h0, PIN_PRESENT_MAP[$past(pin_sel)]}))
        else $error("pin presence readout wrong");
    // A disabled peripheral is never clocked
    a_disabled_no_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((periph_clk_en & ~$past(run_en)) == '0))
        else $error("disabled peripheral clocked");
    // Nor is it ever marked active
    a_active_needs_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((periph_active & ~run_en) == '0))
        else $error("disabled peripheral marked active");
    // Active in the fifth cycle after the enabling write, unless disabled meanwhile
    a_enable_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (hit(OFF_RUN_ON) && !run_en[bus.wdata[SEL_W-1:0]])
        |=> !periph_active[$past(bus.wdata[SEL_W-1:0], 1)]
        ##1 !periph_active[$past(bus.wdata[SEL_W-1:0], 2)]
        ##1 !periph_active[$past(bus.wdata[SEL_W-1:0], 3)]
        ##1 !periph_active[$past(bus.wdata[SEL_W-1:0], 4)]
        ##1 (periph_active[$past(bus.wdata[SEL_W-1:0], 5)]
        || !run_en[$past(bus.wdata[SEL_W-1:0], 5)]))
        else $error("peripheral active at wrong cycle");
    // Any access to a peripheral not yet active faults
    a_fault_on_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (|(periph_access & ~periph_active)) |=> bus_fault)
        else $error("early access gave no fault");
    // And only such an access faults
    a_fault_only_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((periph_access & ~periph_active) == '0) |=> !bus_fault)
        else $error("fault without early access");

endmodule // pcg_top

// ### pcg_pkg.sv
package pcg_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_PERIPH = 32;
    localparam int NUM_PINS   = 32;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int SEL_W      = 5;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFF_RUN_ON     = 8'h00;
    localparam logic [7:0] OFF_RUN_OFF    = 8'h04;
    localparam logic [7:0] OFF_SLEEP_ON   = 8'h08;
    localparam logic [7:0] OFF_SLEEP_OFF  = 8'h0c;
    localparam logic [7:0] OFF_SOFT_RESET = 8'h10;
    localparam logic [7:0] OFF_GATING     = 8'h14;
    localparam logic [7:0] OFF_PIN_QUERY  = 8'h18;
    localparam logic [7:0] OFF_PIN_RESULT = 8'h1c;
    localparam logic [7:0] OFF_RUN_STATE  = 8'h20;
    localparam logic [7:0] OFF_SLEEP_STATE = 8'h24;
    localparam logic [7:0] OFF_ACTIVE     = 8'h28;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int GATING_BIT = 0;
    localparam logic [31:0] RUN_RESET   = 32'h0000_0000;
    localparam logic [31:0] SLEEP_RESET = 32'h0000_0000;
    localparam logic        GATE_RESET  = 1'b0;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int ENABLE_DELAY_CYC = 5;
    localparam int RESET_PULSE_CYC  = 4;
    localparam logic [2:0] ENABLE_DELAY_W = 3'(ENABLE_DELAY_CYC);
    localparam logic [2:0] RESET_PULSE_W  = 3'(RESET_PULSE_CYC);

    // Register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pcg_bus_s;

    // Soft reset sequencer states
    typedef enum logic [0:0] {
        RST_IDLE  = 1'b0,
        RST_PULSE = 1'b1
    } pcg_rst_e;

endpackage

// ### peripheral_clock_gate_reset_bench.sv
module peripheral_clock_gate_reset_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pcg_pkg::*;

    // ************************************************************
    // Signals and design instance
    // ************************************************************
    localparam logic [31:0] PIN_MAP = 32'h0000_00a5;  // Pins 0, 2, 5 and 7 exist

    logic                  clk_sys;
    logic                  rst_n;
    pcg_bus_s              bus;
    logic [DATA_W-1:0]     rdata;
    logic                  cpu_sleep;
    logic [NUM_PERIPH-1:0] periph_access;
    logic [NUM_PERIPH-1:0] periph_clk_en;
    logic [NUM_PERIPH-1:0] periph_rst;
    logic [NUM_PERIPH-1:0] periph_active;
    logic                  bus_fault;
    int                    n_mismatch;
    int                    samples_checked;

    pcg_top #(.PIN_PRESENT_MAP(PIN_MAP)) dut_u (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .bus           (bus),
        .rdata         (rdata),
        .cpu_sleep     (cpu_sleep),
        .periph_access (periph_access),
        .periph_clk_en (periph_clk_en),
        .periph_rst    (periph_rst),
        .periph_active (periph_active),
        .bus_fault     (bus_fault)
    );

    // Free-running system clock
    always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Returns at the edge that takes the write, before its effects land
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge clk_sys);
        bus <= '0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    // Walks cycles 1 to 5 after a write; reset is high for four, active low for four
    task automatic pulse_chk(input int b, input bit is_rst);
        for (int i = 0; i < 5; i++) begin
            #1;
            if (is_rst) begin
                chk("periph_rst", {31'h0, periph_rst[b]}, {31'h0, i < RESET_PULSE_CYC});
                chk("periph_clk_en", periph_clk_en, 32'h0000_0008);
            end else begin
                chk("periph_active", {31'h0, periph_active[b]}, {31'h0, i >= 4});
            end
            if (i < 4) @(posedge clk_sys);
        end
    endtask

    // Lets one registered update land after an input change
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    // ************************************************************
    // Watchdog: the whole sequence needs well under 400 cycles
    // ************************************************************
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        bus = '0;
        cpu_sleep = 1'b0;
        periph_access = '0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Everything off after reset; unmapped reads give zero
        #1;
        chk("periph_clk_en", periph_clk_en, 32'h0);
        rd(OFF_RUN_STATE, RUN_RESET);
        rd(8'h30, READ_UNMAPPED);
        // Run enable: clock one cycle after the enable lands, active five after the write
        wr(OFF_RUN_ON, 32'hffff_ffe3);
        #1;
        chk("periph_clk_en", periph_clk_en, 32'h0);
        pulse_chk(3, 1'b0);
        chk("periph_clk_en", periph_clk_en, 32'h0000_0008);
        // Soft reset pulse with the clock kept running
        wr(OFF_SOFT_RESET, 32'h0000_0003);
        pulse_chk(3, 1'b1);
        chk("periph_active", periph_active, 32'h0000_0008);
        // Access during the enable window faults, after it does not
        wr(OFF_RUN_ON, 32'h0000_0007);
        periph_access <= 32'h0000_0080;
        @(posedge clk_sys);
        periph_access <= '0;
        #1;
        chk("bus_fault", {31'h0, bus_fault}, 32'h1);
        repeat (4) @(posedge clk_sys);
        periph_access <= 32'h0000_0080;
        @(posedge clk_sys);
        periph_access <= '0;
        #1;
        chk("bus_fault", {31'h0, bus_fault}, 32'h0);
        // Sleep with automatic gating on: 3 kept, 7 gated
        wr(OFF_SLEEP_ON, 32'h0000_0003);
        wr(OFF_SLEEP_OFF, 32'h0000_0007);
        wr(OFF_GATING, 32'h0000_0001);
        @(posedge clk_sys);
        cpu_sleep <= 1'b1;
        step();
        chk("periph_clk_en", periph_clk_en, 32'h0000_0008);
        rd(OFF_SLEEP_STATE, 32'h0000_0008);
        // Wake: state kept, no reset, clock back
        @(posedge clk_sys);
        cpu_sleep <= 1'b0;
        step();
        chk("periph_clk_en", periph_clk_en, 32'h0000_0088);
        chk("periph_active", periph_active, 32'h0000_0088);
        chk("periph_rst", periph_rst, 32'h0);
        rd(OFF_ACTIVE, 32'h0000_0088);
        // Gating off: sleep enables stored but without effect
        wr(OFF_GATING, 32'h0000_0000);
        cpu_sleep <= 1'b1;
        step();
        chk("periph_clk_en", periph_clk_en, 32'h0000_0088);
        rd(OFF_SLEEP_STATE, 32'h0000_0008);
        rd(OFF_GATING, 32'h0000_0000);
        @(posedge clk_sys);
        cpu_sleep <= 1'b0;
        // Run disable takes the clock away one cycle after the enable clears
        wr(OFF_RUN_OFF, 32'h0000_0007);
        step();
        chk("periph_clk_en", periph_clk_en, 32'h0000_0008);
        // Pin presence, including a write to the read-only result
        for (int p = 0; p < 8; p++) begin
            wr(OFF_PIN_QUERY, 32'(p));
            wr(OFF_PIN_RESULT, 32'h0000_0001);
            rd(OFF_PIN_RESULT, {31'h0, PIN_MAP[p]});
        end
        rd(OFF_PIN_QUERY, 32'h0000_0007);
        conclude();
    end
endmodule // peripheral_clock_gate_reset_bench
